//--- core/power_stage_supervisor.v
// Summary of operation
// RULE_01: low temperature voltage below threshold trips shutdown
// RULE_02: drive buck enable output
// RULE_03: pwm output trims buck feedback
// RULE_04: one duty step is about 35mV
// RULE_05: high-voltage mode fixes frequency at 127.7kHz
// RULE_06: 5V input: bypass on, buck off
// RULE_07: frequency limits per supply range
// RULE_08: core clock from pll locked to crystal
// RULE_09: power transfer state selects its pattern
// RULE_10: any fault bit selects alarm pattern
// RULE_11: end-transfer done or charge 100 completes
// RULE_12: boot: indicator two toggles thrice, 500 ms; code toggles it six times (2 * BOOT_TOGGLES), 500 ms each
// RULE_13: measure q before every digital ping
// RULE_14: low q with extended receiver blocks transfer
// RULE_15: charge tank, then remove source and short
// RULE_16: q from ringing on ring sense input
// RULE_17: 5V range loads low-voltage set, no epp
// RULE_18: threshold is rx times gain/100 minus offset
// RULE_19: load dump jumps trim to target duty; code jumps duty to dump_duty, not trim_target
// RULE_20: alarm over done over power transfer
// RULE_21: thresholds and patterns software writable live
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "supervisor_defs.vh"

module power_stage_supervisor (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [11:0] remote_temp_sense,
  input  wire        supply_low_range,
  input  wire        pll_locked,
  input  wire        tank_settled,
  input  wire        coil_ring_sense,
  output reg         buck_enable_out,
  output reg         buck_trim_pwm,
  output reg         buck_bypass_out,
  output wire        q_charge_src,
  output wire        q_tank_short,
  output reg         ping_go,
  output reg         ping_blocked,
  output reg  [15:0] freq_count,
  output reg         indicator_one,
  output reg         indicator_two
);

  localparam [15:0] Q_CHARGE_CYCLES = 16'd250;
  localparam [31:0] BOOT_LAST       = 2 * `BOOT_TOGGLES - 1;
  parameter  [31:0] BOOT_TICKS      = (`CLK_HZ / 1000) * `BOOT_TOGGLE_MS;
  parameter  [31:0] STEP_TICKS      = (`CLK_HZ / 1000) * `PAT_STEP_MS;

  function in_range;
    input [11:0] a;
    in_range = (a[11:6] == 6'h00);
  endfunction

  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // input synchronisers
  reg [11:0] temp_s1, temp_s2, temp_s3;
  reg [1:0]  low_s, lock_s, settle_s, ring_s;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp_s1  <= 12'hFFF;
      temp_s2  <= 12'hFFF;
      temp_s3  <= 12'hFFF;
      low_s    <= 2'b00;
      lock_s   <= 2'b00;
      settle_s <= 2'b00;
      ring_s   <= 2'b00;
    end else if (ce) begin
      temp_s1  <= remote_temp_sense;
      temp_s2  <= temp_s1;
      temp_s3  <= temp_s2;
      low_s    <= {low_s[0], supply_low_range};
      lock_s   <= {lock_s[0], pll_locked};
      settle_s <= {settle_s[0], tank_settled};
      ring_s   <= {ring_s[0], coil_ring_sense};
    end
  end

  wire low_v   = low_s[1];
  wire locked  = lock_s[1];

  ////////////////////////////////////////////////////////////////////
  // registers
  reg [7:0]  ctrl;
  reg [11:0] temp_thresh;
  reg [7:0]  trim_target;
  reg [7:0]  dump_duty;
  reg [15:0] freq_req;
  reg [7:0]  q_gain;
  reg [7:0]  q_offset;
  reg [7:0]  q_rx;
  reg [31:0] led_pat;
  reg [31:0] sys_error;
  reg        done_flag;
  reg        boot_done;
  wire       wr_en = psel && penable && pwrite && ce;
  wire       q_done;
  wire       q_busy;
  wire [7:0] q_meas;
  reg        q_start;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !in_range(paddr);
  // temp word is async: act only on a sample seen twice alike
  wire set_ot   = (temp_s2 == temp_s3) &&
                  (temp_s2 < temp_thresh); // RULE_01
  wire [15:0] q_prod = {8'h00, q_rx} * {8'h00, q_gain};
  wire [15:0] q_scaled = q_prod / `Q_GAIN_DIV;
  wire [15:0] q_thresh = (q_scaled > {8'h00, q_offset}) ?
                         q_scaled - {8'h00, q_offset} : 16'h0000; // RULE_18
  wire q_fod_hit = q_done && ctrl[`CTRL_EPP_RX] && !low_v && // RULE_17
                   ({8'h00, q_meas} < q_thresh); // RULE_14

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl        <= 8'h00;
      temp_thresh <= `RST_TEMP_THRESH;
      trim_target <= `RST_TRIM;
      dump_duty   <= `RST_DUMP_DUTY;
      freq_req    <= `RST_FREQ_HV;
      q_gain      <= `RST_Q_GAIN;
      q_offset    <= `RST_Q_OFFSET;
      q_rx        <= 8'h00;
      led_pat     <= `RST_LED_PAT;
      sys_error   <= 32'h0000_0000;
      done_flag   <= 1'b0;
    end else if (ce) begin
      ctrl[`CTRL_LOAD_DUMP] <= 1'b0;
      ctrl[`CTRL_Q_START]   <= 1'b0;
      if (wr_en && paddr == `REG_CTRL && pstrb[0])
        ctrl <= pwdata[7:0];
      if (wr_en && paddr == `REG_TEMP_THRESH && pstrb[0] && pstrb[1])
        temp_thresh <= pwdata[11:0]; // RULE_21
      if (wr_en && paddr == `REG_TRIM) begin
        if (pstrb[0])
          trim_target <= pwdata[7:0];
        if (pstrb[1])
          dump_duty <= pwdata[15:8];
      end
      if (wr_en && paddr == `REG_FREQ && pstrb[0] && pstrb[1])
        freq_req <= pwdata[15:0];
      if (wr_en && paddr == `REG_Q_CFG) begin
        if (pstrb[0])
          q_gain <= pwdata[7:0]; // RULE_21
        if (pstrb[1])
          q_offset <= pwdata[15:8];
      end
      if (wr_en && paddr == `REG_Q_RX && pstrb[0])
        q_rx <= pwdata[7:0];
      if (wr_en && paddr == `REG_LED_PAT && pstrb == 4'hF)
        led_pat <= pwdata; // RULE_21
      if (wr_en && paddr == `REG_ERROR && pstrb == 4'hF)
        sys_error <= sys_error & ~pwdata;
      if (wr_en && paddr == `REG_EVENT && pstrb[0]) begin
        if (pwdata[`EVT_CLEAR_DONE])
          done_flag <= 1'b0;
        if (pwdata[`EVT_EPT_DONE] ||
            pwdata[15:8] == `CHARGE_DONE_VAL)
          done_flag <= 1'b1; // RULE_11
      end
      // hardware set wins over software clear
      if (set_ot)
        sys_error[`ERR_OVER_TEMP] <= 1'b1; // RULE_01
      if (q_fod_hit)
        sys_error[`ERR_Q_FOD] <= 1'b1; // RULE_14
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      prdata <= 32'h0000_0000;
    else if (ce && psel && !penable) begin
      case (paddr)
        `REG_CTRL:        prdata <= {24'h000000, ctrl};
        `REG_TEMP_THRESH: prdata <= {20'h00000, temp_thresh};
        `REG_TRIM:        prdata <= {16'h0000, dump_duty, trim_target};
        `REG_FREQ:        prdata <= {16'h0000, freq_req};
        `REG_Q_CFG:       prdata <= {16'h0000, q_offset, q_gain};
        `REG_Q_RX:        prdata <= {24'h000000, q_rx};
        `REG_LED_PAT:     prdata <= led_pat;
        `REG_STATUS:      prdata <= {22'h000000, boot_done, done_flag,
                                     ping_blocked, q_busy, low_v, locked,
                                     buck_bypass_out, buck_enable_out,
                                     buck_trim_pwm, indicator_two};
        `REG_Q_MEAS:      prdata <= {8'h00, q_thresh, q_meas};
        `REG_ERROR:       prdata <= sys_error;
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // power path and frequency selection
  wire run     = ctrl[`CTRL_RUN] && locked && !sys_error[`ERR_OVER_TEMP]; // RULE_08
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buck_enable_out <= 1'b0;
      buck_bypass_out <= 1'b0;
      freq_count      <= `RST_FREQ_HV;
    end else if (ce) begin
      buck_enable_out <= run && !low_v; // RULE_02
      buck_bypass_out <= run && low_v; // RULE_06
      if (low_v)
        freq_count <= clamp16(freq_req, `RST_FREQ_LV_MIN,
                              `RST_FREQ_LV_MAX); // RULE_07
      else
        freq_count <= `RST_FREQ_HV; // RULE_05
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trim pwm, one duty lsb per buck step
  reg [7:0] pwm_cnt;
  reg [7:0] duty;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwm_cnt       <= 8'h00;
      duty          <= `RST_TRIM;
      buck_trim_pwm <= 1'b0;
    end else if (ce) begin
      pwm_cnt <= pwm_cnt + 8'h01;
      if (ctrl[`CTRL_LOAD_DUMP])
        duty <= dump_duty; // RULE_19
      else if (pwm_cnt == 8'hFF && duty < trim_target)
        duty <= duty + 8'h01; // RULE_04
      else if (pwm_cnt == 8'hFF && duty > trim_target)
        duty <= duty - 8'h01; // RULE_04
      buck_trim_pwm <= buck_enable_out && (pwm_cnt < duty); // RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////
  // q check gates every ping
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_start      <= 1'b0;
      ping_go      <= 1'b0;
      ping_blocked <= 1'b0;
    end else if (ce) begin
      q_start <= ctrl[`CTRL_Q_START] && run && !q_busy; // RULE_13
      ping_go <= q_done && !q_fod_hit;
      if (q_done)
        ping_blocked <= q_fod_hit; // RULE_14
    end
  end
  q_factor_meter u_qmeter (
    .clk           (clk),
    .resetn        (resetn),
    .ce            (ce),
    .start         (q_start),
    .tank_settled  (settle_s[1]),
    .ring_hi       (ring_s[1]),
    .charge_cycles (Q_CHARGE_CYCLES),
    .charge_src_on (q_charge_src),
    .tank_short    (q_tank_short),
    .busy          (q_busy),
    .done          (q_done),
    .q_value       (q_meas)
  );

  ////////////////////////////////////////////////////////////////////
  // indicators
  reg [31:0] tick;
  reg [2:0]  boot_cnt;
  reg [2:0]  step;
  reg [1:0]  mode;
  always @* begin
    if (sys_error != 32'h0000_0000)
      mode = `MODE_ALARM; // RULE_10
    else if (done_flag)
      mode = `MODE_DONE; // RULE_11
    else if (ctrl[`CTRL_PT_REQ] && !ping_blocked)
      mode = `MODE_PT; // RULE_09
    else
      mode = `MODE_IDLE; // RULE_20
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick          <= 32'h0000_0000;
      boot_cnt      <= 3'd0;
      boot_done     <= 1'b0;
      step          <= 3'd0;
      indicator_one <= 1'b0;
      indicator_two <= 1'b0;
    end else if (ce) begin
      if (!boot_done) begin
        // fixed boot blink, patterns not consulted
        if (tick >= BOOT_TICKS - 32'd1) begin
          tick          <= 32'h0000_0000;
          indicator_two <= ~indicator_two; // RULE_12
          boot_cnt      <= boot_cnt + 3'd1;
          if (boot_cnt == BOOT_LAST[2:0])
            boot_done <= 1'b1; // RULE_12
        end else
          tick <= tick + 32'd1;
      end else begin
        if (tick >= STEP_TICKS - 32'd1) begin
          tick <= 32'h0000_0000;
          step <= step + 3'd1;
        end else
          tick <= tick + 32'd1;
        case (mode)
          `MODE_ALARM: begin
            indicator_one <= led_pat[{2'd3, step}];
            indicator_two <= led_pat[{2'd2, step}];
          end
          `MODE_DONE: begin
            indicator_one <= led_pat[{2'd1, step}];
            indicator_two <= led_pat[{2'd0, step} + 5'd8];
          end
          `MODE_PT: begin
            indicator_one <= led_pat[{2'd0, step}];
            indicator_two <= 1'b0;
          end
          default: begin
            indicator_one <= 1'b0;
            indicator_two <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

//--- core/supervisor_defs.vh
`ifndef SUPERVISOR_DEFS_VH
`define SUPERVISOR_DEFS_VH

// register byte offsets
`define REG_CTRL          12'h000
`define REG_TEMP_THRESH   12'h004
`define REG_TRIM          12'h008
`define REG_FREQ          12'h00C
`define REG_Q_CFG         12'h010
`define REG_Q_RX          12'h014
`define REG_EVENT         12'h018
`define REG_LED_PAT       12'h01C
`define REG_STATUS        12'h020
`define REG_Q_MEAS        12'h024
`define REG_ERROR         12'h028

// control bits
`define CTRL_RUN          0
`define CTRL_EPP_RX       1
`define CTRL_PT_REQ       2
`define CTRL_LOAD_DUMP    3
`define CTRL_Q_START      4

// event bits (write one to signal; EVT_CHARGE_100 is ignored)
`define EVT_EPT_DONE      0
`define EVT_CHARGE_100    1
`define EVT_CLEAR_DONE    2

// error bits
`define ERR_OVER_TEMP     14
`define ERR_Q_FOD         22

// reset values
`define RST_TEMP_THRESH   12'h400
`define RST_TRIM          8'h80
`define RST_DUMP_DUTY     8'h20
`define RST_Q_GAIN        8'h64
`define RST_Q_OFFSET      8'h00
`define RST_LED_PAT       32'h00F0_0FAA
`define RST_FREQ_HV       16'h0342
`define RST_FREQ_LV_MIN   16'h02D0
`define RST_FREQ_LV_MAX   16'h0388

// timing and figures
`define CLK_HZ            250000000
`define BOOT_TOGGLE_MS    500
`define BOOT_TOGGLES      3
`define PAT_STEP_MS       125
`define TRIM_STEP_MV      35
`define CHARGE_DONE_VAL   8'h64
`define Q_GAIN_DIV        16'd100
`define XTAL_HZ           8000000
`define FIXED_FREQ_HZ     127700
`define LV_FREQ_MIN_HZ    110000
`define LV_FREQ_MAX_HZ    148000
`define HV_FREQ_MIN_HZ    110000

// indicator modes
`define MODE_IDLE         2'd0
`define MODE_PT           2'd1
`define MODE_DONE         2'd2
`define MODE_ALARM        2'd3

`endif

//--- core/q_factor_meter.v
`timescale 1ns/1ps
`include "supervisor_defs.vh"

module q_factor_meter (
  input  wire        clk,
  input  wire        resetn,
  input  wire        ce,
  input  wire        start,
  input  wire        tank_settled,
  input  wire        ring_hi,
  input  wire [15:0] charge_cycles,
  output reg         charge_src_on,
  output reg         tank_short,
  output reg         busy,
  output reg         done,
  output reg  [7:0]  q_value
);

  localparam S_IDLE   = 2'd0;
  localparam S_CHARGE = 2'd1;
  localparam S_RING   = 2'd2;

  reg [1:0]  state;
  reg [15:0] timer;
  reg [7:0]  peaks;
  reg        ring_prev;

  ////////////////////////////////////////////////////////////////////
  // ringing counted in whole periods until the envelope falls
  // below the sense comparator; count of periods tracks q
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state         <= S_IDLE;
      timer         <= 16'h0000;
      peaks         <= 8'h00;
      ring_prev     <= 1'b0;
      charge_src_on <= 1'b0;
      tank_short    <= 1'b0;
      busy          <= 1'b0;
      done          <= 1'b0;
      q_value       <= 8'h00;
    end else if (ce) begin
      done      <= 1'b0;
      ring_prev <= ring_hi;
      case (state)
        S_IDLE: begin
          if (start) begin
            state         <= S_CHARGE;
            charge_src_on <= 1'b1; // RULE_15
            busy          <= 1'b1;
            timer         <= 16'h0000;
          end
        end
        S_CHARGE: begin
          timer <= timer + 16'h0001;
          if (tank_settled && timer >= charge_cycles) begin
            charge_src_on <= 1'b0; // RULE_15
            tank_short    <= 1'b1;
            peaks         <= 8'h00;
            timer         <= 16'h0000;
            state         <= S_RING;
          end
        end
        S_RING: begin
          timer <= timer + 16'h0001;
          if (ring_hi && !ring_prev) begin
            timer <= 16'h0000;
            if (peaks != 8'hFF)
              peaks <= peaks + 8'h01; // RULE_16
          end else if (timer == 16'hFFFF) begin
            q_value    <= peaks; // RULE_16
            tank_short <= 1'b0;
            busy       <= 1'b0;
            done       <= 1'b1;
            state      <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

//--- test/analog_stage_model.sv
`timescale 1ns/1ps
module analog_stage_model #(
  parameter int SETTLE = 260,
  parameter int RINGS  = 20
) (
  input  wire  clk,
  input  wire  resetn,
  input  wire  q_charge_src,
  input  wire  q_tank_short,
  output logic tank_settled,
  output logic coil_ring_sense
);
  int chg;
  int ph;
  int n;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chg <= 0;
      ph <= 0;
      n <= 0;
      tank_settled <= 1'b0;
      coil_ring_sense <= 1'b0;
    end else begin
      // ac current dies out only after a long charge
      chg <= q_charge_src ? chg + 1 : 0;
      tank_settled <= q_charge_src && chg >= SETTLE;
      if (!q_tank_short) begin
        ph <= 0;
        n <= 0;
        coil_ring_sense <= 1'b0;
      end else if (n < 2 * RINGS) begin
        ph <= (ph == 3) ? 0 : ph + 1;
        if (ph == 3) begin
          n <= n + 1;
          coil_ring_sense <= ~coil_ring_sense;
        end
      end
    end
  end
endmodule

//--- test/supervisor_sva.sv
`timescale 1ns/1ps
module supervisor_sva (
  input wire        clk,
  input wire        resetn,
  input wire        supply_low_range,
  input wire        pll_locked,
  input wire        tank_settled,
  input wire        buck_enable_out,
  input wire        buck_bypass_out,
  input wire        q_charge_src,
  input wire        q_tank_short,
  input wire        ping_go,
  input wire        ping_blocked,
  input wire [15:0] freq_count
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////
  a_one_path: assert property (
    !(buck_enable_out && buck_bypass_out))
    else $error("buck and bypass on together");
  a_low_no_buck: assert property (
    supply_low_range [*6] |-> !buck_enable_out)
    else $error("buck on with low supply");
  a_high_no_bypass: assert property (
    !supply_low_range [*6] |-> !buck_bypass_out)
    else $error("bypass on with high supply");
  a_unlocked_off: assert property (
    !pll_locked [*6] |-> !(buck_enable_out || buck_bypass_out))
    else $error("power path on without lock");
  a_fixed_freq: assert property (
    !supply_low_range [*6] |-> freq_count == 16'h0342)
    else $error("high range frequency not fixed");
  a_freq_range: assert property (
    freq_count >= 16'h02D0 && freq_count <= 16'h0388)
    else $error("frequency count out of range");
  a_q_exclusive: assert property (
    !(q_charge_src && q_tank_short))
    else $error("tank charged and shorted together");
  a_short_after: assert property (
    $rose(q_tank_short) |-> $past(q_charge_src) || $past(q_charge_src, 2))
    else $error("tank shorted without charge");
  a_settle_first: assert property (
    $fell(q_charge_src) |-> $past(tank_settled))
    else $error("source removed before settling");
  a_block_no_ping: assert property (
    ping_blocked |-> !ping_go)
    else $error("ping issued while blocked");
endmodule

bind power_stage_supervisor supervisor_sva u_supervisor_sva (
  .clk, .resetn, .supply_low_range, .pll_locked, .tank_settled,
  .buck_enable_out, .buck_bypass_out, .q_charge_src, .q_tank_short,
  .ping_go, .ping_blocked, .freq_count);

//--- test/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct {
    logic        lo;
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0]  eb;
    logic [15:0] f;
  } row_t;
  logic        clk, resetn, ce, psel, penable, pwrite, low, locked;
  logic [11:0] paddr, temp;
  logic [31:0] pwdata, rd, prdata;
  logic        pready, pslverr, settled, ring, en, byp, pwm, qc, qs;
  logic        go, blk, ind1, ind2, err, p, seen_go, seen_sh;
  logic [15:0] freq;
  int          n_fail, compares, cnt;
  row_t        rows [9] = '{
    '{1'b0, 1'b0, 12'h004, 32'h0, 32'hFFF, 32'h400, 2'h0, 16'h0342},
    '{1'b0, 1'b0, 12'h008, 32'h0, 32'hFFFF, 32'h2080, 2'h0, 16'h0},
    '{1'b0, 1'b0, 12'h010, 32'h0, 32'hFFFF, 32'h0064, 2'h0, 16'h0},
    '{1'b0, 1'b0, 12'h01C, 32'h0, 32'hFFFFFFFF, 32'h00F00FAA, 2'h0, 16'h0},
    '{1'b0, 1'b1, 12'h000, 32'h1, 32'h1, 32'h1, 2'h2, 16'h0342},
    '{1'b1, 1'b1, 12'h00C, 32'h100, 32'hFFFF, 32'h100, 2'h1, 16'h02D0},
    '{1'b1, 1'b1, 12'h00C, 32'h400, 32'hFFFF, 32'h400, 2'h1, 16'h0388},
    '{1'b1, 1'b1, 12'h00C, 32'h300, 32'hFFFF, 32'h300, 2'h1, 16'h0300},
    '{1'b0, 1'b1, 12'h004, 32'h123, 32'hFFF, 32'h123, 2'h2, 16'h0342}};

  power_stage_supervisor #(.BOOT_TICKS(32'd20), .STEP_TICKS(32'd8))
    u_power_stage_supervisor (
    .clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .pready, .prdata, .pslverr, .remote_temp_sense(temp),
    .supply_low_range(low), .pll_locked(locked), .tank_settled(settled),
    .coil_ring_sense(ring), .buck_enable_out(en), .buck_trim_pwm(pwm),
    .buck_bypass_out(byp), .q_charge_src(qc), .q_tank_short(qs),
    .ping_go(go), .ping_blocked(blk), .freq_count(freq),
    .indicator_one(ind1), .indicator_two(ind2));
  analog_stage_model u_analog_stage_model (
    .clk, .resetn, .q_charge_src(qc), .q_tank_short(qs),
    .tank_settled(settled), .coil_ring_sense(ring));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (go === 1'b1) seen_go = 1'b1;
    if (qs === 1'b1) seen_sh = 1'b1;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string what);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // any 64-cycle window holds one full 8-step pattern
  task ind_meas;
    repeat (70) @(posedge clk);
    cnt = 0;
    repeat (64) begin
      @(posedge clk);
      cnt += ind1;
    end
  endtask
  task end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, psel, penable, pwrite, low, locked} = 6'h0;
    {seen_go, seen_sh} = 2'h0;
    ce = 1'b1;
    paddr = 12'h0;
    pwdata = 32'h0;
    temp = 12'hFFF;
    repeat (5) @(posedge clk);
    check(freq, 16'h0342, "freq in reset");
    check(en, 1'b0, "buck in reset");
    resetn <= 1'b1;
    p = 1'b0;
    cnt = 0;
    repeat (135) begin
      @(posedge clk);
      if (ind2 !== p) cnt++;
      p = ind2;
    end
    check(cnt, 6, "boot toggles");
    apb(1'b0, 12'h020, 32'h0);
    check(rd[9], 1'b1, "boot done");
    locked <= 1'b1;
    foreach (rows[i]) begin
      low <= rows[i].lo;
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      repeat (8) @(posedge clk);
      apb(1'b0, rows[i].a, 32'h0);
      check(rd & rows[i].m, rows[i].e, "register");
      check(err, 1'b0, "slave error");
      check({en, byp}, rows[i].eb, "power path");
      if (rows[i].f != 0) check(freq, rows[i].f, "freq");
    end
    apb(1'b0, 12'h040, 32'h0);
    check(err, 1'b1, "bad address");
    check(rd, 32'h0, "bad address read");
    apb(1'b1, 12'h01C, 32'h0F070301);
    apb(1'b1, 12'h000, 32'h5);
    ind_meas;
    check(cnt, 8, "transfer pattern");
    apb(1'b1, 12'h018, 32'h1);
    ind_meas;
    check(cnt, 16, "done pattern");
    apb(1'b1, 12'h018, 32'h4);
    ind_meas;
    check(cnt, 8, "done cleared");
    apb(1'b1, 12'h018, 32'h6400);
    ind_meas;
    check(cnt, 16, "charge status done");
    temp <= 12'h100;
    ind_meas;
    check(cnt, 32, "alarm pattern");
    check(en, 1'b0, "buck when hot");
    apb(1'b0, 12'h028, 32'h0);
    check(rd[14], 1'b1, "overtemp flag");
    temp <= 12'hFFF;
    apb(1'b1, 12'h028, 32'h4000);
    repeat (8) @(posedge clk);
    check(en, 1'b1, "buck after clear");
    // target equals dump duty so no ramp blurs the count
    apb(1'b1, 12'h008, 32'h2020);
    apb(1'b1, 12'h000, 32'h9);
    repeat (300) @(posedge clk);
    cnt = 0;
    repeat (256) begin
      @(posedge clk);
      cnt += pwm;
    end
    check(cnt, 32, "trim duty");
    apb(1'b1, 12'h014, 32'hC8);
    apb(1'b0, 12'h024, 32'h0);
    check(rd[23:8], 16'd200, "q threshold");
    apb(1'b1, 12'h010, 32'h0A32);
    apb(1'b0, 12'h024, 32'h0);
    check(rd[23:8], 16'd90, "q threshold");
    apb(1'b1, 12'h010, 32'h0064);
    apb(1'b1, 12'h000, 32'h13);
    cnt = 0;
    while (blk !== 1'b1 && !seen_go && cnt < 70000) begin
      @(posedge clk);
      cnt++;
    end
    check(blk, 1'b1, "ping blocked");
    check(seen_go, 1'b0, "ping issued");
    check(seen_sh, 1'b1, "tank shorted");
    apb(1'b0, 12'h028, 32'h0);
    check(rd[22], 1'b1, "q fault flag");
    // a write while the clock enable is low must be lost
    ce <= 1'b0;
    apb(1'b1, 12'h014, 32'h55);
    ce <= 1'b1;
    apb(1'b0, 12'h014, 32'h0);
    check(rd, 32'hC8, "write with enable low");
    end_of_test;
  end
endmodule
